// File: hw/power_calc_pkg.sv
// Purpose: Shared constants and types of the shunt power calculation engine
// Assumes: 40 MHz system clock, 16-bit register words
// Notes: Conversion-time and averaging tables are indexed by the 3-bit setup fields
package power_calc_pkg;

	localparam logic [2:0] REG_SETUP = 3'h0;
	localparam logic [2:0] REG_SHUNT = 3'h1;
	localparam logic [2:0] REG_SUPPLY = 3'h2;
	localparam logic [2:0] REG_WATT = 3'h3;
	localparam logic [2:0] REG_AMP = 3'h4;
	localparam logic [2:0] REG_SCALE = 3'h5;

	localparam logic [15:0] SETUP_RESET = 16'h0127;
	localparam logic [15:0] SCALE_RESET = 16'h0000;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [15:0] SETUP_MASK = 16'h0fff;

	localparam int AVG_LSB = 9;
	localparam int BUS_CT_LSB = 6;
	localparam int SHUNT_CT_LSB = 3;

	localparam int CLK_MHZ = 40;
	localparam int CLK_PERIOD_NS = 25;
	localparam int CT_MIN_US = 140;
	localparam int CT_MAX_US = 8244;
	localparam int CT_US [8] = '{CT_MIN_US, 204, 332, 588, 1100, 2116, 4156, CT_MAX_US};
	localparam int AVG_SHIFT [8] = '{0, 2, 4, 6, 7, 8, 9, 10};

	localparam int SAMPLE_RATE_KHZ = 500;
	localparam int MOD_HALF_CYCLES = (CLK_MHZ * 1000) / (SAMPLE_RATE_KHZ * 2);

	localparam int CURRENT_SHIFT = 11;
	localparam logic [32:0] CURRENT_ROUND = 33'h0_0000_07ff;
	localparam logic [15:0] POWER_DIVISOR = 16'h4e20;
	localparam logic [5:0] DIV_STEPS = 6'h20;

	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [2:0] addr;
		logic [15:0] wrData;
	} reg_req_t;

	typedef enum logic [1:0] {
		SEQ_SHUNT_CONV = 2'b00,
		SEQ_SHUNT_CALC = 2'b01,
		SEQ_BUS_CONV = 2'b10,
		SEQ_BUS_CALC = 2'b11
	} seq_state_t;

endpackage : power_calc_pkg

// File: hw/power_quotient_unit.sv
// Purpose: Sequential unsigned division of a power product by the fixed power divisor
// Assumes: start is a one-cycle pulse, never given while busy
// Notes: Thirty-two steps, one quotient bit per clock
`timescale 1ns/1ps
module power_quotient_unit
	import power_calc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic [31:0] dividend,
	output logic [15:0] quotient,
	output logic done
);

	logic [15:0] rem_q;
	logic [31:0] quo_q;
	logic [5:0] cnt_q;
	logic busy_q;
	logic done_q;
	logic [15:0] trial;
	logic fits;

	assign trial = {rem_q[14:0], quo_q[31]};
	assign fits = trial >= POWER_DIVISOR;
	assign quotient = quo_q[15:0];
	assign done = done_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rem_q <= 16'h0000;
			quo_q <= 32'h0000_0000;
			cnt_q <= 6'h00;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start) begin
				rem_q <= 16'h0000;
				quo_q <= dividend;
				cnt_q <= DIV_STEPS;
				busy_q <= 1'b1;
			end else if (busy_q) begin
				rem_q <= fits ? trial - POWER_DIVISOR : trial;
				quo_q <= {quo_q[30:0], fits};
				cnt_q <= cnt_q - 6'h01;
				if (cnt_q == 6'h01) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end
			end
		end
	end

endmodule : power_quotient_unit

// File: hw/shunt_power_calc_engine.sv
// Purpose: Measurement sequencing and current/power arithmetic of a shunt monitor
// Assumes: Converter result words arrive from the analog domain and are synchronised here
// Notes: Register port is the internal side of the serial register pointer; read data lags one clock
`timescale 1ns/1ps
module shunt_power_calc_engine
	import power_calc_pkg::*;
#(
	parameter int CyclesPerUs = CLK_MHZ
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire reg_req_t regReq,
	output logic [15:0] regRdData,
	output logic regRdValid,
	input wire logic [15:0] shuntCode,
	input wire logic [15:0] supply_sense_input,
	output logic modClk,
	output logic convBusy
);

	function automatic logic [23:0] convCycles(input logic [2:0] sel);
		int cyc;
		cyc = CT_US[sel] * CyclesPerUs;
		return cyc[23:0];
	endfunction : convCycles

	function automatic logic [15:0] avgSigned(input logic signed [26:0] acc, input logic [2:0] sel);
		logic signed [26:0] sh;
		sh = acc >>> AVG_SHIFT[sel];
		return sh[15:0];
	endfunction : avgSigned

	logic [15:0] setup_q, scale_q, shuntRes_q, supplyRes_q, wattRes_q, ampRes_q;
	logic [15:0] regRdData_q;
	logic regRdValid_q;
	logic calWritten_q;
	logic [15:0] shuntSync1_q, shuntSync2_q, busSync1_q, busSync2_q;
	logic [7:0] modCnt_q;
	logic modClk_q;
	seq_state_t state_q;
	logic [23:0] timer_q;
	logic [10:0] sampleCnt_q;
	logic [15:0] shuntSample_q, curSample_q;
	logic [14:0] busSample_q;
	logic signed [26:0] shuntAcc_q, ampAcc_q;
	logic [25:0] busAcc_q, wattAcc_q;
	logic divStart_q;

	logic setupWr, scaleWr, timerDone, lastSample, divDone;
	logic [2:0] avgSel, shuntCtSel, busCtSel;
	logic [10:0] avgCount;
	logic signed [32:0] curProd, curAdj;
	logic [32:0] curShift;
	logic [15:0] curAbs, wattQuot, readMux;
	logic [31:0] wattProd;

	assign setupWr = regReq.wrEn && regReq.addr == REG_SETUP;
	assign scaleWr = regReq.wrEn && regReq.addr == REG_SCALE;
	assign avgSel = setup_q[AVG_LSB +: 3];
	assign busCtSel = setup_q[BUS_CT_LSB +: 3];
	assign shuntCtSel = setup_q[SHUNT_CT_LSB +: 3];
	assign avgCount = 11'h001 << AVG_SHIFT[avgSel];
	assign lastSample = sampleCnt_q == avgCount - 11'h001;
	assign timerDone = timer_q == 24'h000000;

	// Signed shunt times unsigned scale, negative products biased so the shift truncates toward zero
	assign curProd = $signed(shuntSync2_q) * $signed({1'b0, scale_q});
	assign curAdj = curProd[32] ? curProd + $signed(CURRENT_ROUND) : curProd;
	assign curShift = curAdj >>> CURRENT_SHIFT;
	assign curAbs = curSample_q[15] ? 16'h0000 - curSample_q : curSample_q;
	assign wattProd = curAbs * {1'b0, busSample_q};

	// Window sums including the sample that closes the window
	logic [25:0] busSum, wattSum;
	logic [15:0] busAvg, wattAvg;
	logic convBusy_q;

	assign busSum = busAcc_q + {11'h000, busSample_q};
	assign wattSum = wattAcc_q + {10'h000, wattQuot};
	assign busAvg = avgSigned($signed({1'b0, busSum}), avgSel);
	assign wattAvg = avgSigned($signed({1'b0, wattSum}), avgSel);

	always_comb begin
		unique case (regReq.addr)
			REG_SETUP: readMux = setup_q;
			REG_SHUNT: readMux = shuntRes_q;
			REG_SUPPLY: readMux = supplyRes_q;
			REG_WATT: readMux = wattRes_q;
			REG_AMP: readMux = ampRes_q;
			REG_SCALE: readMux = scale_q;
			default: readMux = 16'h0000;
		endcase
	end

	power_quotient_unit quotient (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(divStart_q),
		.dividend(wattProd),
		.quotient(wattQuot),
		.done(divDone)
	);

	assign regRdData = regRdData_q;
	assign regRdValid = regRdValid_q;
	assign modClk = modClk_q;
	assign convBusy = convBusy_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			setup_q <= SETUP_RESET;
			scale_q <= SCALE_RESET;
			calWritten_q <= 1'b0;
			regRdData_q <= 16'h0000;
			regRdValid_q <= 1'b0;
			convBusy_q <= 1'b0;
		end else begin
			// Continuous conversion only: busy from the first edge after reset
			convBusy_q <= 1'b1;
			regRdValid_q <= regReq.rdEn;
			if (regReq.rdEn) begin
				regRdData_q <= readMux;
			end
			if (setupWr) begin
				setup_q <= regReq.wrData & SETUP_MASK;
			end
			if (scaleWr) begin
				scale_q <= regReq.wrData;
				calWritten_q <= 1'b1;
			end
		end
	end

	// Analog-domain result words pass two flops before use
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			shuntSync1_q <= 16'h0000;
			shuntSync2_q <= 16'h0000;
			busSync1_q <= 16'h0000;
			busSync2_q <= 16'h0000;
		end else begin
			shuntSync1_q <= shuntCode;
			shuntSync2_q <= shuntSync1_q;
			busSync1_q <= supply_sense_input;
			busSync2_q <= busSync1_q;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			modCnt_q <= 8'h00;
			modClk_q <= 1'b0;
		end else if (modCnt_q == 8'(MOD_HALF_CYCLES - 1)) begin
			modCnt_q <= 8'h00;
			modClk_q <= ~modClk_q;
		end else begin
			modCnt_q <= modCnt_q + 8'h01;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= SEQ_SHUNT_CONV;
			timer_q <= 24'h000000;
			sampleCnt_q <= 11'h000;
			shuntSample_q <= 16'h0000;
			curSample_q <= 16'h0000;
			busSample_q <= 15'h0000;
			shuntAcc_q <= 27'sh0;
			ampAcc_q <= 27'sh0;
			busAcc_q <= 26'h0;
			wattAcc_q <= 26'h0;
			divStart_q <= 1'b0;
			shuntRes_q <= RESULT_RESET;
			supplyRes_q <= RESULT_RESET;
			wattRes_q <= RESULT_RESET;
			ampRes_q <= RESULT_RESET;
		end else if (setupWr) begin
			// New settings restart the averaging window
			state_q <= SEQ_SHUNT_CONV;
			timer_q <= convCycles(regReq.wrData[SHUNT_CT_LSB +: 3]);
			sampleCnt_q <= 11'h000;
			shuntAcc_q <= 27'sh0;
			ampAcc_q <= 27'sh0;
			busAcc_q <= 26'h0;
			wattAcc_q <= 26'h0;
			divStart_q <= 1'b0;
		end else begin
			divStart_q <= 1'b0;
			unique case (state_q)
				SEQ_SHUNT_CONV: begin
					timer_q <= timer_q - 24'h000001;
					if (timerDone) begin
						shuntSample_q <= shuntSync2_q;
						curSample_q <= calWritten_q ? curShift[15:0] : 16'h0000;
						state_q <= SEQ_SHUNT_CALC;
					end
				end
				SEQ_SHUNT_CALC: begin
					shuntAcc_q <= shuntAcc_q + 27'($signed(shuntSample_q));
					ampAcc_q <= ampAcc_q + 27'($signed(curSample_q));
					timer_q <= convCycles(busCtSel);
					state_q <= SEQ_BUS_CONV;
				end
				SEQ_BUS_CONV: begin
					timer_q <= timer_q - 24'h000001;
					if (timerDone) begin
						busSample_q <= busSync2_q[14:0];
						divStart_q <= 1'b1;
						state_q <= SEQ_BUS_CALC;
					end
				end
				SEQ_BUS_CALC: begin
					if (divDone) begin
						busAcc_q <= busSum;
						wattAcc_q <= wattSum;
						timer_q <= convCycles(shuntCtSel);
						state_q <= SEQ_SHUNT_CONV;
						if (lastSample) begin
							// Averages reach the result registers only at window end
							sampleCnt_q <= 11'h000;
							shuntRes_q <= avgSigned(shuntAcc_q, avgSel);
							ampRes_q <= calWritten_q ? avgSigned(ampAcc_q, avgSel) : 16'h0000;
							supplyRes_q <= {1'b0, busAvg[14:0]};
							wattRes_q <= calWritten_q ? wattAvg : 16'h0000;
							shuntAcc_q <= 27'sh0;
							ampAcc_q <= 27'sh0;
							busAcc_q <= 26'h0;
							wattAcc_q <= 26'h0;
						end else begin
							sampleCnt_q <= sampleCnt_q + 11'h001;
						end
					end
				end
			endcase
		end
	end

endmodule : shunt_power_calc_engine

// File: verif/power_calc_engine_properties.sv
// Purpose: Port assertions of the shunt power calculation engine
// Assumes: One clock, asynchronous active-high reset
// Notes: Bound to the design top
`timescale 1ns/1ps
module power_calc_engine_checker
	import power_calc_pkg::*;
#(
	parameter int CyclesPerUs = CLK_MHZ
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire reg_req_t regReq,
	input wire logic [15:0] regRdData,
	input wire logic regRdValid,
	input wire logic modClk
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic modPrev_q;
	logic seen_q;
	logic [7:0] cnt_q;
	wire toggle = modClk != modPrev_q;
	wire rd = regReq.rdEn;
	wire wrSetup = regReq.wrEn && regReq.addr == REG_SETUP;
	wire wrScale = regReq.wrEn && regReq.addr == REG_SCALE;
	// Counts clocks since the sampling clock last changed
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			modPrev_q <= 1'b0;
			seen_q <= 1'b0;
			cnt_q <= 8'h00;
		end else begin
			modPrev_q <= modClk;
			seen_q <= seen_q | toggle;
			cnt_q <= toggle ? 8'h00 : cnt_q + 8'h01;
		end
	end
	property p_rd_valid; rd |=> regRdValid; endproperty
	a_rd_valid: assert property (p_rd_valid) else $error("no read answer");
	property p_no_valid; !rd |=> !regRdValid; endproperty
	a_no_valid: assert property (p_no_valid) else $error("spurious read answer");
	property p_unmapped; rd && regReq.addr > REG_SCALE |=> regRdData == 16'h0000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_setup_wr;
		wrSetup ##1 !regReq.wrEn ##1 (rd && !regReq.wrEn && regReq.addr == REG_SETUP)
			|=> regRdData == ($past(regReq.wrData, 3) & SETUP_MASK);
	endproperty
	a_setup_wr: assert property (p_setup_wr) else $error("setup readback wrong");
	property p_scale_wr;
		wrScale ##1 !regReq.wrEn ##1 (rd && !regReq.wrEn && regReq.addr == REG_SCALE)
			|=> regRdData == $past(regReq.wrData, 3);
	endproperty
	a_scale_wr: assert property (p_scale_wr) else $error("scale readback wrong");
	property p_supply_msb; rd && regReq.addr == REG_SUPPLY |=> !regRdData[15]; endproperty
	a_supply_msb: assert property (p_supply_msb) else $error("bus result top bit set");
	property p_mod_half; toggle && seen_q |-> cnt_q == MOD_HALF_CYCLES - 1; endproperty
	a_mod_half: assert property (p_mod_half) else $error("sampling half period wrong");
	property p_mod_bound; seen_q |-> cnt_q < MOD_HALF_CYCLES; endproperty
	a_mod_bound: assert property (p_mod_bound) else $error("sampling clock stalled");
	property p_stands; !rd |=> $stable(regRdData); endproperty
	a_stands: assert property (p_stands) else $error("read data changed unasked");
	c_scale: cover property (wrScale);
	c_amp: cover property (rd && regReq.addr == REG_AMP);
	c_setup: cover property (wrSetup ##2 rd);
	c_scale_rd: cover property (wrScale ##2 (rd && regReq.addr == REG_SCALE));
endmodule : power_calc_engine_checker
bind shunt_power_calc_engine power_calc_engine_checker #(.CyclesPerUs(CyclesPerUs)) i_power_calc_engine_checker (
	.clk(clk), .sys_rst(sys_rst), .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid), .modClk(modClk));

// File: verif/reg_host_model.sv
// Purpose: Host model that programs and reads the engine registers
// Assumes: Strobes held for one clock, inputs changed just after an edge
// Notes: Read data is taken once the answer has settled
`timescale 1ns/1ps
module reg_host_model
	import power_calc_pkg::*;
(
	input wire logic clk,
	output reg_req_t regReq,
	input wire logic [15:0] regRdData,
	input wire logic regRdValid
);
	initial regReq = '0;
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		#1 regReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
		@(posedge clk);
		#1 regReq = '0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk);
		#1 regReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 16'h0000};
		@(posedge clk);
		#1 regReq = '0;
		d = regRdValid ? regRdData : 16'hxxxx;
	endtask : rd
endmodule : reg_host_model

// File: verif/testbench.sv
// Purpose: Self-checking bench of the shunt power calculation engine
// Assumes: Conversion times shortened by CyclesPerUs of 1
// Notes: Result waits span at least one whole averaging window, except the wait before the mid-window read
`timescale 1ns/1ps
module testbench
	import power_calc_pkg::*;
;
	typedef struct {logic [15:0] sh, bus, cal, busExp, curExp, powExp;} row_t;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] shuntCode = 16'h0000;
	logic [15:0] supplyCode = 16'h0000;
	reg_req_t regReq;
	logic [15:0] regRdData;
	logic [15:0] rdVal;
	logic regRdValid;
	logic modClk;
	logic convBusy;
	int fails = 0;
	int total_checks = 0;
	// Last row: negative current truncates toward zero
	row_t rows [4] = '{'{16'h1f40, 16'h2570, 16'h0a00, 16'h2570, 16'h2710, 16'h12b8},
		'{16'he0c0, 16'ha570, 16'h0a00, 16'h2570, 16'hd8f0, 16'h12b8},
		'{16'h0003, 16'h0001, 16'h03e8, 16'h0001, 16'h0001, 16'h0000},
		'{16'hfffd, 16'h4e20, 16'h03e8, 16'h4e20, 16'hffff, 16'h0001}};
	always #12.5 clk = ~clk;
	shunt_power_calc_engine #(.CyclesPerUs(1)) i_shunt_power_calc_engine (.clk(clk), .sys_rst(sys_rst),
		.regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid), .shuntCode(shuntCode),
		.supply_sense_input(supplyCode), .modClk(modClk), .convBusy(convBusy));
	reg_host_model i_reg_host_model (.clk(clk), .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid));
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic rdChk(input logic [2:0] a, input string name, input logic [15:0] exp);
		i_reg_host_model.rd(a, rdVal);
		chk(name, exp, rdVal);
	endtask : rdChk
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
	endtask : settle
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	initial begin
		repeat (2) @(posedge clk);
		#1 sys_rst = 1'b0;
		rdChk(REG_SETUP, "setup", SETUP_RESET);
		rdChk(REG_SCALE, "scale", SCALE_RESET);
		chk("conv busy", 16'h0001, {15'h0000, convBusy});
		i_reg_host_model.wr(REG_SETUP, 16'hf007);
		rdChk(REG_SETUP, "setup masked", 16'h0007);
		shuntCode = rows[0].sh;
		supplyCode = rows[0].bus;
		settle(700);
		rdChk(REG_AMP, "current uncal", 16'h0000);
		rdChk(REG_WATT, "power uncal", 16'h0000);
		i_reg_host_model.wr(REG_SHUNT, 16'h1234);
		rdChk(REG_SHUNT, "shunt", 16'h1f40);
		rdChk(3'h6, "unmapped", 16'h0000);
		$display("test reset_and_access done");
		foreach (rows[i]) begin
			i_reg_host_model.wr(REG_SCALE, rows[i].cal);
			rdChk(REG_SCALE, "scale", rows[i].cal);
			shuntCode = rows[i].sh;
			supplyCode = rows[i].bus;
			settle(700);
			rdChk(REG_SUPPLY, "bus", rows[i].busExp);
			rdChk(REG_AMP, "current", rows[i].curExp);
			rdChk(REG_WATT, "power", rows[i].powExp);
			$display("test row %0d done", i);
		end
		i_reg_host_model.wr(REG_SCALE, 16'h0a00);
		i_reg_host_model.wr(REG_SETUP, 16'h0207);
		shuntCode = rows[0].sh;
		supplyCode = rows[0].bus;
		settle(700);
		rdChk(REG_AMP, "current mid window", 16'hffff);
		settle(1900);
		rdChk(REG_AMP, "current averaged", 16'h2710);
		$display("test averaging done");
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		finish_test();
	end
endmodule : testbench
